// [include/acc_pkg.sv]
package acc_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_SC1    = 8'h00;
  localparam logic [7:0]  ADDR_SC2    = 8'h04;
  localparam logic [7:0]  ADDR_RESH   = 8'h08;
  localparam logic [7:0]  ADDR_RESL   = 8'h0C;
  localparam logic [7:0]  ADDR_CVH    = 8'h10;
  localparam logic [7:0]  ADDR_CVL    = 8'h14;
  localparam logic [7:0]  ADDR_ISTAT  = 8'h18;
  localparam logic [7:0]  ADDR_IMASK  = 8'h1C;
  localparam logic [4:0]  CH_OFF      = 5'h1F;
  localparam logic [4:0]  CH_REFH     = 5'h1D;
  localparam logic [4:0]  CH_REFL     = 5'h1E;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          EV_W        = 2;
  localparam int          EV_DONE     = 0;
  localparam int          EV_ABORT    = 1;
  localparam int          LOW_W       = 8;

  typedef struct packed {
    logic       flag;
    logic       irqEn;
    logic       cont;
    logic [4:0] chan;
  } acc_sc1_type;

  typedef struct packed {
    logic       active;
    logic       hwTrig;
    logic       cmpEn;
    logic       cmpGe;
    logic [3:0] rsvd;
  } acc_sc2_type;

  localparam acc_sc1_type SC1_RESET = '{flag: 1'b0, irqEn: 1'b0, cont: 1'b0, chan: CH_OFF};
  localparam acc_sc2_type SC2_RESET = '{active: 1'b0, hwTrig: 1'b0, cmpEn: 1'b0, cmpGe: 1'b0, rsvd: 4'h0};

  typedef enum logic {
    ACC_IDLE,
    ACC_CONV
  } acc_state_type;
endpackage

// [rtl/acc_top.sv]
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module acc_top #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  // axi4-lite write address
  input  wire logic [acc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // axi4-lite write data and response
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [acc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // hardware trigger from periodic counter
  input  wire logic                       hwTrigger,
  // converter core
  input  wire logic                       convDone,
  input  wire logic [RES_W-1:0]           convResult,
  output logic                            convStart,
  output logic                            convAbort,
  output logic                            convPowerOn,
  output logic [4:0]                      convChannel,
  // interrupt
  output logic                            irq
);

  localparam int HI_W = RES_W - acc_pkg::LOW_W;

  if (RES_W < 9 || RES_W > 16) begin : g_chk
    $error("acc_top: RES_W must lie in 9..16");
  end

  // register state
  acc_pkg::acc_sc1_type   sc1;
  acc_pkg::acc_sc2_type   sc2;
  acc_pkg::acc_state_type state;
  logic [RES_W-1:0]       result;
  logic [RES_W-1:0]       cmpVal;
  logic [acc_pkg::EV_W-1:0] evStat;
  logic [acc_pkg::EV_W-1:0] evMask;

  // trigger synchroniser
  logic trigSync1;
  logic trigSync2;
  logic trigPrev;

  // write channel holding
  logic                       awHeld;
  logic                       wHeld;
  logic [acc_pkg::ADDR_W-1:0] awAddr;
  logic [31:0]                wData;
  logic [3:0]                 wStrb;

  // bus handshakes
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake  = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
  wire rdTake = s_axi_arvalid & s_axi_arready;

  wire next_awHeld = awHeld ? ~doWrite : awTake;
  wire next_wHeld  = wHeld ? ~doWrite : wTake;
  wire next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);
  wire next_rvalid = rdTake | (s_axi_rvalid & ~s_axi_rready);

  // write decode
  wire hitSc1   = awAddr == acc_pkg::ADDR_SC1;
  wire hitSc2   = awAddr == acc_pkg::ADDR_SC2;
  wire hitCvh   = awAddr == acc_pkg::ADDR_CVH;
  wire hitCvl   = awAddr == acc_pkg::ADDR_CVL;
  wire hitImask = awAddr == acc_pkg::ADDR_IMASK;
  wire hitRo    = awAddr == acc_pkg::ADDR_RESH ||
                  awAddr == acc_pkg::ADDR_RESL ||
                  awAddr == acc_pkg::ADDR_ISTAT;
  wire wrMapped = hitSc1 | hitSc2 | hitCvh | hitCvl | hitImask | hitRo;
  wire lane0    = doWrite & wStrb[0];
  wire wrSc1    = lane0 & hitSc1;
  wire wrSc2    = lane0 & hitSc2;
  wire wrCvh    = lane0 & hitCvh;
  wire wrCvl    = lane0 & hitCvl;
  wire wrImask  = lane0 & hitImask;

  // read decode
  wire rdResl  = rdTake & (s_axi_araddr == acc_pkg::ADDR_RESL);
  wire rdIstat = rdTake & (s_axi_araddr == acc_pkg::ADDR_ISTAT);

  // written view of status_control_one
  acc_pkg::acc_sc1_type wrView;
  assign wrView = acc_pkg::acc_sc1_type'(wData[7:0]);

  // written view of control two, fields placed by the package type
  acc_pkg::acc_sc2_type wr2View;
  assign wr2View = acc_pkg::acc_sc2_type'(wData[7:0]);

  // trigger edge, read only from the second stage
  wire trigEvent = trigSync2 & ~trigPrev;

  // conversion control
  wire converting = state == acc_pkg::ACC_CONV;
  wire chanOff    = sc1.chan == acc_pkg::CH_OFF;
  wire wrChanOn   = wrView.chan != acc_pkg::CH_OFF;
  wire swStart    = wrSc1 & wrChanOn & ~sc2.hwTrig;
  wire hwStart    = sc2.hwTrig & trigEvent & ~chanOff & ~converting & ~wrSc1;
  wire abortNow   = wrSc1 & converting;
  // a done that coincides with the abort belongs to the aborted conversion
  wire endConv    = convDone & converting & ~wrSc1;
  wire cmpHit     = sc2.cmpGe ? (convResult >= cmpVal) : (convResult < cmpVal);
  wire cmpTrue    = ~sc2.cmpEn | cmpHit;
  wire keepResult = endConv & cmpTrue;
  wire restart    = endConv & sc1.cont & ~chanOff;
  wire startNow   = swStart | hwStart | restart;

  acc_pkg::acc_state_type next_state;
  assign next_state = startNow ? acc_pkg::ACC_CONV :
                      (endConv | wrSc1) ? acc_pkg::ACC_IDLE : state;

  // done flag: a new result wins over a clear in the same cycle
  wire next_flag = keepResult | (sc1.flag & ~wrSc1 & ~rdResl);

  acc_pkg::acc_sc1_type next_sc1;
  assign next_sc1 = wrSc1 ? {next_flag, wrView.irqEn, wrView.cont, wrView.chan} :
                            {next_flag, sc1.irqEn, sc1.cont, sc1.chan};

  wire [acc_pkg::EV_W-1:0] evSet = {abortNow, endConv};
  wire [acc_pkg::EV_W-1:0] next_evStat = (evStat & ~{acc_pkg::EV_W{rdIstat}}) | evSet;
  wire [acc_pkg::EV_W-1:0] next_evMask = wrImask ? wData[acc_pkg::EV_W-1:0] : evMask;

  wire next_irq = (next_sc1.flag & next_sc1.irqEn) | (|(next_evStat & next_evMask));

  // read data selection
  acc_pkg::acc_sc2_type sc2View;
  assign sc2View = '{active: converting, hwTrig: sc2.hwTrig, cmpEn: sc2.cmpEn,
                     cmpGe: sc2.cmpGe, rsvd: 4'h0};

  wire [31:0] rdSc1   = 32'(sc1);
  wire [31:0] rdSc2   = 32'(sc2View);
  wire [31:0] rdResh  = 32'(result[RES_W-1:acc_pkg::LOW_W]);
  wire [31:0] rdLow   = 32'(result[acc_pkg::LOW_W-1:0]);
  wire [31:0] rdCvh   = 32'(cmpVal[RES_W-1:acc_pkg::LOW_W]);
  wire [31:0] rdCvl   = 32'(cmpVal[acc_pkg::LOW_W-1:0]);
  wire [31:0] rdIst   = 32'(evStat);
  wire [31:0] rdImk   = 32'(evMask);
  wire [acc_pkg::ADDR_W-1:0] ra = s_axi_araddr;
  wire rdMapped = ra == acc_pkg::ADDR_SC1 || ra == acc_pkg::ADDR_SC2 ||
                  ra == acc_pkg::ADDR_RESH || ra == acc_pkg::ADDR_RESL ||
                  ra == acc_pkg::ADDR_CVH || ra == acc_pkg::ADDR_CVL ||
                  ra == acc_pkg::ADDR_ISTAT || ra == acc_pkg::ADDR_IMASK;
  wire [31:0] rdData = ra == acc_pkg::ADDR_SC1   ? rdSc1  :
                       ra == acc_pkg::ADDR_SC2   ? rdSc2  :
                       ra == acc_pkg::ADDR_RESH  ? rdResh :
                       ra == acc_pkg::ADDR_RESL  ? rdLow  :
                       ra == acc_pkg::ADDR_CVH   ? rdCvh  :
                       ra == acc_pkg::ADDR_CVL   ? rdCvl  :
                       ra == acc_pkg::ADDR_ISTAT ? rdIst  :
                       ra == acc_pkg::ADDR_IMASK ? rdImk  : 32'h0000_0000;

  // compare value by byte register
  wire [RES_W-1:0] next_cmpVal = {wrCvh ? wData[HI_W-1:0] : cmpVal[RES_W-1:acc_pkg::LOW_W],
                                  wrCvl ? wData[acc_pkg::LOW_W-1:0] : cmpVal[acc_pkg::LOW_W-1:0]};

  // bus slave
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= '0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acc_pkg::RESP_OKAY;
    end else begin
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      s_axi_awready <= ~next_awHeld & ~next_bvalid;
      s_axi_wready  <= ~next_wHeld & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (awTake) begin
        awAddr <= s_axi_awaddr;
      end
      if (wTake) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bresp <= wrMapped ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= acc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (rdTake) begin
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdMapped ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end
    end
  end

  // trigger pin crossing
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      trigSync1 <= 1'b0;
      trigSync2 <= 1'b0;
      trigPrev  <= 1'b0;
    end else begin
      trigSync1 <= hwTrigger;
      trigSync2 <= trigSync1;
      trigPrev  <= trigSync2;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sc1    <= acc_pkg::SC1_RESET;
      sc2    <= acc_pkg::SC2_RESET;
      cmpVal <= '0;
      evStat <= '0;
      evMask <= '0;
    end else begin
      sc1    <= next_sc1;
      cmpVal <= next_cmpVal;
      evStat <= next_evStat;
      evMask <= next_evMask;
      if (wrSc2) begin
        sc2.hwTrig <= wr2View.hwTrig;
        sc2.cmpEn  <= wr2View.cmpEn;
        sc2.cmpGe  <= wr2View.cmpGe;
      end
    end
  end

  // conversion sequencing
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state       <= acc_pkg::ACC_IDLE;
      result      <= '0;
      convStart   <= 1'b0;
      convAbort   <= 1'b0;
      convPowerOn <= 1'b0;
      convChannel <= acc_pkg::CH_OFF;
      irq         <= 1'b0;
    end else begin
      state       <= next_state;
      convStart   <= startNow;
      convAbort   <= abortNow;
      // powered only while converting; all ones also isolates the input
      convPowerOn <= next_state == acc_pkg::ACC_CONV;
      convChannel <= next_sc1.chan;
      irq         <= next_irq;
      if (keepResult) begin
        result <= convResult;
      end
    end
  end

endmodule

// [bench/acc_asserts.sv]
`timescale 1ns/10ps
module acc_asserts (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  // register bus
  input  wire logic [acc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  input  wire logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  input  wire logic                       s_axi_wready,
  input  wire logic [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_bvalid,
  // converter and interrupt
  input  wire logic                       convDone,
  input  wire logic                       convStart,
  input  wire logic                       convAbort,
  input  wire logic                       convPowerOn,
  input  wire logic [4:0]                 convChannel,
  input  wire logic                       irq
);
  logic [7:0] aq;
  logic [7:0] dq;
  logic       lane, bvPrev, irqEnQ, contQ, hwSelQ, cmpEnQ, maskQ;
  wire        wrEv  = s_axi_bvalid && !bvPrev && s_axi_bresp == acc_pkg::RESP_OKAY && lane;
  wire        sc1Wr = wrEv && aq == acc_pkg::ADDR_SC1;
  // shadows follow the response, one cycle behind the register itself
  always_ff @(posedge mclk) begin
    bvPrev <= rstn && s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) aq <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) dq <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) lane <= s_axi_wstrb[0];
    if (!rstn) {irqEnQ, contQ, hwSelQ, cmpEnQ, maskQ} <= '0;
    else if (sc1Wr) {irqEnQ, contQ} <= dq[6:5];
    else if (wrEv && aq == acc_pkg::ADDR_SC2) {hwSelQ, cmpEnQ} <= dq[6:5];
    else if (wrEv && aq == acc_pkg::ADDR_IMASK) maskQ <= |dq[1:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  start_on_write_a: assert property (sc1Wr && dq[4:0] != acc_pkg::CH_OFF && !hwSelQ |-> ##[0:1] convStart)
    else $error("no start after channel write");
  abort_when_busy_a: assert property (convAbort |-> $past(convPowerOn))
    else $error("abort without running conversion");
  off_no_start_a: assert property (convStart |-> convChannel != acc_pkg::CH_OFF)
    else $error("start with converter off");
  stop_no_extra_a: assert property (sc1Wr && dq[4:0] == acc_pkg::CH_OFF |-> !convStart ##1 !convStart)
    else $error("extra conversion after stop");
  single_down_a: assert property (convDone && convPowerOn && !contQ |=> !convPowerOn)
    else $error("power kept after single conversion");
  cont_restart_a: assert property (convDone && convPowerOn && contQ && convChannel != acc_pkg::CH_OFF |=> convStart)
    else $error("continuous mode did not restart");
  done_irq_a: assert property (convDone && convPowerOn && irqEnQ && !cmpEnQ |-> ##[1:3] irq)
    else $error("no interrupt after conversion end");
  irq_masked_a: assert property (!irqEnQ && !maskQ && !s_axi_bvalid |=> !irq)
    else $error("interrupt while all sources disabled");
endmodule

bind acc_top acc_asserts u_chk (
  .mclk(mclk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .convDone(convDone),
  .convStart(convStart), .convAbort(convAbort), .convPowerOn(convPowerOn), .convChannel(convChannel), .irq(irq));

// [bench/acc_top_tb_top.sv]
`timescale 1ns/10ps
module acc_top_tb_top;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        mclk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hwTrigger, convDone, convStart, convAbort;
  logic        convPowerOn, irq;
  logic [9:0]  convResult, res, lastRes;
  logic [4:0]  convChannel;
  logic [33:0] expQ[$];
  logic [1:0]  respQ[$];
  int          bad_count, tests_run, starts, aborts, want, seed, i;
  logic [4:0]  chans[6] = '{5'h00, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h07};
  logic [20:0] cmpCases[4] = '{{8'h20, 10'h300, 3'd0}, {8'h20, 10'h1FF, 3'd1}, {8'h30, 10'h200, 3'd1}, {8'h30, 10'h1FF, 3'd0}};

  acc_top u_dut (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .hwTrigger(hwTrigger), .convDone(convDone), .convResult(convResult), .convStart(convStart),
    .convAbort(convAbort), .convPowerOn(convPowerOn), .convChannel(convChannel), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic hang;
    bad_count++;
    finish_test();
  endtask

  // pulses are one cycle wide, so count them rather than poll
  always @(posedge mclk) begin
    starts <= starts + int'(convStart === 1'b1);
    aborts <= aborts + int'(convAbort === 1'b1);
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(respQ.pop_front()));
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    respQ.push_back(er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    expQ.push_back({er, 24'h000000, d});
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) hang();
  endtask

  task automatic convEnd(input logic [9:0] r);
    @(posedge mclk);
    convResult <= r;
    convDone <= 1'b1;
    @(posedge mclk);
    convDone <= 1'b0;
  endtask

  task automatic waitStarts(input int n);
    want = want + n;
    for (i = 0; i < 20 && starts < want; i++) @(posedge mclk);
    if (starts < want) hang();
    check(34'(starts), 34'(want));
  endtask

  initial begin
    seed = 32'h5B05;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, hwTrigger, convDone, convResult, rstn, lastRes} = '0;
    s_axi_wstrb = 4'hF;
    chans[5] = 5'($unsigned($random(seed)) % 28);
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rd(acc_pkg::ADDR_SC1, 8'h1F, acc_pkg::RESP_OKAY);
    rd(8'h20, 8'h00, acc_pkg::RESP_SLVERR);
    wr(8'h20, 8'h55, acc_pkg::RESP_SLVERR);
    wr(acc_pkg::ADDR_IMASK, 8'h01, acc_pkg::RESP_OKAY);
    foreach (chans[c]) begin
      res = 10'($random(seed));
      wr(acc_pkg::ADDR_SC1, {3'b010, chans[c]}, acc_pkg::RESP_OKAY);
      waitStarts(1);
      check(34'(convChannel), 34'(chans[c]));
      convEnd(res);
      repeat (2) @(posedge mclk);
      check(34'({irq, convPowerOn}), 34'(2'b10));
      rd(acc_pkg::ADDR_SC1, {3'b110, chans[c]}, acc_pkg::RESP_OKAY);
      rd(acc_pkg::ADDR_RESH, {6'h00, res[9:8]}, acc_pkg::RESP_OKAY);
      rd(acc_pkg::ADDR_RESL, res[7:0], acc_pkg::RESP_OKAY);
      rd(acc_pkg::ADDR_ISTAT, 8'h01, acc_pkg::RESP_OKAY);
      rd(acc_pkg::ADDR_SC1, {3'b010, chans[c]}, acc_pkg::RESP_OKAY);
      repeat (2) @(posedge mclk);
      check(34'(irq), 34'(1'b0));
    end
    wr(acc_pkg::ADDR_SC1, 8'h25, acc_pkg::RESP_OKAY);
    waitStarts(1);
    convEnd(10'($random(seed)));
    waitStarts(1);
    wr(acc_pkg::ADDR_SC1, 8'h3F, acc_pkg::RESP_OKAY);
    repeat (8) @(posedge mclk);
    check(34'({starts[7:0], aborts[7:0], convPowerOn, convChannel}), 34'({want[7:0], 8'd1, 1'b0, 5'h1F}));
    wr(acc_pkg::ADDR_SC1, 8'h02, acc_pkg::RESP_OKAY);
    waitStarts(1);
    wr(acc_pkg::ADDR_SC1, 8'h03, acc_pkg::RESP_OKAY);
    waitStarts(1);
    check(34'({aborts[7:0], convChannel}), 34'({8'd2, 5'h03}));
    rd(acc_pkg::ADDR_ISTAT, 8'h03, acc_pkg::RESP_OKAY);
    lastRes = 10'($random(seed));
    convEnd(lastRes);
    wr(acc_pkg::ADDR_CVH, 8'h02, acc_pkg::RESP_OKAY);
    wr(acc_pkg::ADDR_CVL, 8'h00, acc_pkg::RESP_OKAY);
    foreach (cmpCases[c]) begin
      wr(acc_pkg::ADDR_SC2, cmpCases[c][20:13], acc_pkg::RESP_OKAY);
      wr(acc_pkg::ADDR_SC1, 8'h01, acc_pkg::RESP_OKAY);
      waitStarts(1);
      convEnd(cmpCases[c][12:3]);
      if (cmpCases[c][0]) lastRes = cmpCases[c][12:3];
      rd(acc_pkg::ADDR_SC1, {cmpCases[c][0], 7'h01}, acc_pkg::RESP_OKAY);
      rd(acc_pkg::ADDR_RESL, lastRes[7:0], acc_pkg::RESP_OKAY);
    end
    wr(acc_pkg::ADDR_SC2, 8'h40, acc_pkg::RESP_OKAY);
    wr(acc_pkg::ADDR_SC1, 8'h04, acc_pkg::RESP_OKAY);
    // give a wrong software start time to reach the counter
    repeat (4) @(posedge mclk);
    waitStarts(0);
    hwTrigger <= 1'b1;
    waitStarts(1);
    hwTrigger <= 1'b0;
    convEnd(10'($random(seed)));
    repeat (8) @(posedge mclk);
    check(34'({starts, convPowerOn}), 34'({want, 1'b0}));
    wr(acc_pkg::ADDR_SC1, 8'h24, acc_pkg::RESP_OKAY);
    repeat (4) @(posedge mclk);
    waitStarts(0);
    hwTrigger <= 1'b1;
    waitStarts(1);
    hwTrigger <= 1'b0;
    convEnd(10'($random(seed)));
    waitStarts(1);
    wr(acc_pkg::ADDR_SC1, 8'h1F, acc_pkg::RESP_OKAY);
    repeat (8) @(posedge mclk);
    check(34'({starts[7:0], aborts[7:0], convPowerOn}), 34'({want[7:0], 8'd3, 1'b0}));
    finish_test();
  end
endmodule
